// File: dv/cmd_source.sv
// bus-side command source feeding the filter
// send is called right after a rising clock edge
`timescale 1ns/1ns
module cmd_source
(
  input wire logic core_clk,
  output logic cmdValid = 1'h0,
  output logic busIdle = 1'h1,
  output logic [15:0] cmdWord = 16'h0000
);
  // word is inverted once its cycle is over, never left standing
  task send(input logic [15:0] w, input logic idle);
    cmdValid <= 1'h1;
    busIdle <= idle;
    cmdWord <= w;
    @(posedge core_clk);
    cmdValid <= 1'h0;
    cmdWord <= ~w;
  endtask
endmodule // cmd_source

// File: dv/filter_chk_asserts.sv
// checker for the filter top ports
// bound to every instance of the filter
`timescale 1ns/1ns
module filter_chk
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hostSel,
  input wire logic [15:0] hostAddr,
  input wire logic hostHit,
  input wire logic hostAck,
  input wire logic cmdValid,
  input wire logic busIdle,
  input wire logic msgValid,
  input wire logic msgRecord,
  input wire logic msgIgnore,
  input wire logic clearBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_dec_lat: assert property
    (cmdValid && busIdle && !clearBusy |-> ##2 msgValid) else $error("late");
  a_busy_cmd: assert property
    (cmdValid && clearBusy |-> ##2 !msgValid) else $error("early");
  a_idle_cmd: assert property
    (cmdValid && !busIdle |-> ##2 !msgValid) else $error("not idle");
  a_one_hot: assert property
    (msgValid |-> msgRecord ^ msgIgnore) else $error("both or none");
  a_no_stray: assert property
    (!msgValid |-> !msgRecord && !msgIgnore) else $error("stray");
  a_hit_map: assert property
    (hostHit == (hostSel && hostAddr >= 16'h0100 && hostAddr <= 16'h017F))
    else $error("bad hit");
  a_ack_lat: assert property
    (hostHit && !clearBusy && !cmdValid |-> ##1 hostAck) else $error("no ack");
  a_clr_end: assert property
    (clearBusy |-> ##[1:130] !clearBusy) else $error("sweep hangs");
endmodule // filter_chk
bind monitor_message_filter filter_chk u_chk(.core_clk, .rst, .hostSel,
  .hostAddr, .hostHit, .hostAck, .cmdValid, .busIdle, .msgValid,
  .msgRecord, .msgIgnore, .clearBusy);

// File: dv/tb_top.sv
// self-checking bench for the filter
// needs the checker and the command source
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'h0, rst = 1'h1, hostSel = 1'h0, hostWr = 1'h0;
  logic [15:0] hostAddr = 16'h0000, hostWdata = 16'h0000, hostRdata, q;
  logic [15:0] cmdWord;
  logic hostAck, hostHit, cmdValid, busIdle, msgValid, msgRecord;
  logic msgIgnore, clearBusy;
  int fails = 0, cmpCount = 0, cyc = 0, i;
  logic [16:0] rows [6] = '{
    {16'h0000, 1'h1},
    {16'h0020, 1'h0},
    {16'h2E20, 1'h1},
    {16'h2C20, 1'h0},
    {16'h2A20, 1'h0},
    {16'h2620, 1'h0}};
  monitor_message_filter dut(.core_clk, .rst, .hostSel, .hostWr, .hostAddr,
    .hostWdata, .hostRdata, .hostAck, .hostHit, .cmdValid, .busIdle,
    .cmdWord, .msgValid, .msgRecord, .msgIgnore, .clearBusy);
  cmd_source src(.core_clk, .cmdValid, .busIdle, .cmdWord);
  task complete_run;
    if (fails == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmpCount++;
    if (s !== e)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task host(input logic wr, input logic [15:0] a, input logic [15:0] d);
    hostSel <= 1'h1;
    hostWr <= wr;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge core_clk);
    hostSel <= 1'h0;
    hostWdata <= ~d;
    @(posedge core_clk);
    chk(hostAck, a >= 16'h0100 && a <= 16'h017F);
    @(posedge core_clk);
    q = hostRdata;
  endtask
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fails++;
      complete_run;
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    src.send(16'h0000, 1'h1);
    repeat (2) @(posedge core_clk);
    chk(msgValid, 16'h0000);
    for (i = 0; i < 200 && clearBusy; i++) @(posedge core_clk);
    chk(clearBusy, 16'h0000);
    host(1'h0, 16'h0100, 16'h0000);
    chk(q, 16'h0000);
    host(1'h0, 16'h017F, 16'h0000);
    chk(q, 16'h0000);
    host(1'h1, 16'h0100, 16'h0001);
    host(1'h1, 16'h0117, 16'h0002);
    host(1'h0, 16'h0117, 16'h0000);
    chk(q, 16'h0002);
    host(1'h0, 16'h0180, 16'h0000);
    for (i = 0; i < 6; i++)
    begin
      src.send(rows[i][16:1], 1'h1);
      repeat (2) @(posedge core_clk);
      chk(msgValid, 16'h0001);
      chk(msgIgnore, rows[i][0]);
      chk(msgRecord, !rows[i][0]);
    end
    src.send(16'h0020, 1'h0);
    repeat (2) @(posedge core_clk);
    chk(msgValid, 16'h0000);
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    for (i = 0; i < 200 && clearBusy; i++) @(posedge core_clk);
    chk(clearBusy, 16'h0000);
    host(1'h0, 16'h0117, 16'h0000);
    chk(q, 16'h0000);
    src.send(rows[0][16:1], 1'h1);
    repeat (2) @(posedge core_clk);
    chk(msgRecord, 16'h0001);
    complete_run;
  end
endmodule // tb_top

// File: rtl/filter_ram.v
// 128 x 16 bitmap store with registered read port and a single write port
// assumes the owner sequences the sweep and keeps the host off meanwhile
`timescale 1ns/1ns
module filter_ram
(
  // clock
  input wire core_clk,
  // write port
  input wire wrEn,
  input wire [6:0] wrIdx,
  input wire [15:0] wrData,
  // read port
  input wire rdEn,
  input wire [6:0] rdIdx,
  output reg [15:0] rdData
);
  reg [15:0] mem [0:127];

  always @(posedge core_clk)
  begin
    if (wrEn)
      mem[wrIdx] <= wrData;
    if (rdEn)
      rdData <= mem[rdIdx];
  end
endmodule // filter_ram

// File: rtl/monitor_message_filter.v
// bitmap lookup deciding whether the monitor records each new message
// assumes host ram accesses and decoded command words are synchronous
`timescale 1ns/1ns
`include "msg_filter_defs.vh"

// Notes on behaviour
// - the bitmap is 128 sixteen-bit words at fixed ram base 0x0100.
// - a selected bit of 1 ignores the message, a bit of 0 records it.
// - after master reset all words 0x0100-0x017F read 0x0000.
// - each valid command word on an idle bus outside the clearing sweep starts a filtered message.
// - the word is picked by terminal address, T/R and subaddress msb.
// - each terminal owns four words, two receive and two transmit.
// - words run rx 15-0, rx 31-16, tx 15-0, tx 31-16; bit n is sa n or n+16.
// - terminal k starts at base plus four times k.
module monitor_message_filter
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // host ram port (word addresses)
  input wire hostSel,
  input wire hostWr,
  input wire [15:0] hostAddr,
  input wire [15:0] hostWdata,
  output reg [15:0] hostRdata,
  output reg hostAck,
  output wire hostHit,
  // command words from the decoder
  input wire cmdValid,
  input wire busIdle,
  input wire [15:0] cmdWord,
  // decision to the recording logic
  output reg msgValid,
  output reg msgRecord,
  output reg msgIgnore,
  output wire clearBusy
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_CLEAR = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_LOOK = 4'h4;
  localparam [3:0] ST_HOST = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [6:0] clrIdx_r;
  reg [3:0] bitSel_r;
  reg [6:0] lookIdx;
  reg ramWe;
  reg [6:0] ramWIdx;
  reg [15:0] ramWData;
  reg ramRe;
  reg [6:0] ramRIdx;
  wire [15:0] ramQ;
  wire hostInRange;
  wire [15:0] hostOff;
  wire newMsg;
  wire cmdTake;
  wire [4:0] cmdTa;
  wire cmdTr;
  wire cmdSaMsb;
  wire [3:0] cmdSaLow;
  wire hostTake;
  wire hostRead;
  wire lastClr;
  reg hostRd_r;

  // ----------------------------------------
  // host window decode
  // ----------------------------------------
  // only the low seven offset bits matter once the range check has passed
  assign hostOff = hostAddr - `FLT_BASE_ADDR;
  assign hostInRange = (hostAddr >= `FLT_BASE_ADDR) &&
                       (hostAddr <= `FLT_LAST_ADDR);
  assign hostHit = hostSel && hostInRange;
  assign clearBusy = state_r == ST_CLEAR;
  // a command in the same cycle wins, so the host sees no ack and retries
  assign hostTake = hostHit && !newMsg && !clearBusy;
  assign hostRead = hostTake && !hostWr;

  // ----------------------------------------
  // command word fields
  // ----------------------------------------
  assign cmdTa = cmdWord[`CMD_TA_HI:`CMD_TA_LO];
  assign cmdTr = cmdWord[`CMD_TR_BIT];
  assign cmdSaMsb = cmdWord[`CMD_SA_MSB];
  assign cmdSaLow = cmdWord[`CMD_SA_B3:`CMD_SA_LO3];
  assign newMsg = cmdValid && busIdle;
  // commands arriving during the sweep are dropped, not queued
  assign cmdTake = newMsg && !clearBusy;
  assign lastClr = clrIdx_r == `FLT_LAST_IDX;

  // ----------------------------------------
  // index from command word
  // ----------------------------------------
  // ta*4 + tr*2 + sa msb gives the four-word groups per terminal
  always @*
  begin
    lookIdx = {cmdTa, cmdTr, cmdSaMsb};
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // a pending command wins over the host so no message start is missed outside the clearing sweep
  always @*
  begin
    state_nxt = state_r;
    ramWe = 1'b0;
    ramWIdx = clrIdx_r;
    ramWData = `FLT_WORD_RESET;
    ramRe = 1'b0;
    ramRIdx = lookIdx;
    case (state_r)
      ST_CLEAR:
      begin
        ramWe = 1'b1;
        if (lastClr)
          state_nxt = ST_IDLE;
      end
      ST_IDLE, ST_LOOK, ST_HOST:
      begin
        if (newMsg)
        begin
          ramRe = 1'b1;
          state_nxt = ST_LOOK;
        end
        else if (hostHit)
        begin
          ramRIdx = hostOff[6:0];
          ramRe = !hostWr;
          ramWe = hostWr;
          ramWIdx = hostOff[6:0];
          ramWData = hostWdata;
          state_nxt = ST_HOST;
        end
        else
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_CLEAR;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= ST_CLEAR;
      bitSel_r <= 4'h0;
      hostAck <= 1'b0;
      hostRd_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (cmdTake)
        bitSel_r <= cmdSaLow;
      hostAck <= hostTake;
      hostRd_r <= hostRead;
    end
  end

  // ----------------------------------------
  // clearing sweep
  // ----------------------------------------
  // every reset restarts the sweep, so a reset in mid-run also wipes
  // whatever the host wrote before it
  always @(posedge core_clk)
  begin
    if (rst)
      clrIdx_r <= `FLT_IDX_ZERO;
    else if (clearBusy)
      clrIdx_r <= clrIdx_r + 7'h01;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      msgValid <= 1'b0;
      msgRecord <= 1'b0;
      msgIgnore <= 1'b0;
    end
    else
    begin
      msgValid <= state_r == ST_LOOK;
      msgIgnore <= (state_r == ST_LOOK) && ramQ[bitSel_r];
      msgRecord <= (state_r == ST_LOOK) && !ramQ[bitSel_r];
    end
  end

  // read data stands until the next read; writes leave it alone
  always @(posedge core_clk)
  begin
    if (rst)
      hostRdata <= 16'h0000;
    else if (hostRd_r)
      hostRdata <= ramQ;
  end

  // ----------------------------------------
  // bitmap store
  // ----------------------------------------
  // the state machine hands the ports to one user per cycle
  filter_ram u_ram
  (
    .core_clk(core_clk),
    .wrEn(ramWe),
    .wrIdx(ramWIdx),
    .wrData(ramWData),
    .rdEn(ramRe),
    .rdIdx(ramRIdx),
    .rdData(ramQ)
  );
endmodule // monitor_message_filter

// File: rtl/msg_filter_defs.vh
// constants for the monitor message selection bitmap
// assumes a 16-bit word-addressed ram port and a 16-bit command word
`ifndef MSG_FILTER_DEFS_VH
`define MSG_FILTER_DEFS_VH
`define FLT_BASE_ADDR 16'h0100
`define FLT_LAST_ADDR 16'h017F
`define FLT_WORDS 128
`define FLT_IDX_W 7
`define FLT_LAST_IDX 7'h7F
`define FLT_IDX_ZERO 7'h00
`define FLT_WORD_RESET 16'h0000
// command word fields
`define CMD_TA_HI 15
`define CMD_TA_LO 11
`define CMD_TR_BIT 10
`define CMD_SA_MSB 9
`define CMD_SA_LO3 5
`define CMD_SA_B3 8
`endif
